// *** core/sound_envelope_duration_irq.sv ***
module sound_envelope_duration_irq
  import sound_env_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             reset,
  input  wire logic [sound_env_pkg::ADDR_W-1:0] addr,
  input  wire logic [sound_env_pkg::DATA_W-1:0] wdata,
  input  wire logic                             wr,
  input  wire logic                             rd,
  output logic      [sound_env_pkg::DATA_W-1:0] rdata,
  input  wire logic                             tone,
  output logic      [sound_env_pkg::AMP_W-1:0]  live_amplitude,
  output logic                                  reload_pulse,
  output logic                                  stop_pulse,
  output logic                                  running,
  output logic                                  irq
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic             config_ready_ff;
  logic             stop_req_ff;
  logic             env_en_ff;
  shape_e           env_shape_ff;
  logic             env_dir_ff;
  logic [AMP_W-1:0] cfg_amp_ff;
  logic [AMP_W-1:0] amp_step_ff;
  logic [AMP_W-1:0] amp_thr_ff;
  logic [DUR_W-1:0] dur_ff;
  logic             irq_en_ff;
  logic             next_data_flag_ff;

  logic              en_buf_ff;
  shape_e            shape_buf_ff;
  logic              dir_buf_ff;
  logic [AMP_W-1:0]  step_buf_ff;
  logic [AMP_W-1:0]  thr_buf_ff;
  logic [DUR_W-1:0]  dur_buf_ff;
  logic [AMP_W-1:0]  live_amp_ff;
  logic [FRAC_W-1:0] frac_ff;
  run_e              state_ff;
  logic [DATA_W-1:0] rdata_ff;

  logic [DUR_W-1:0]  count;
  logic              dur_end;
  logic [AMP_W-1:0]  nxt_amp;
  logic [FRAC_W-1:0] nxt_frac;
  logic              reached;
  logic              start_evt;
  logic              reload_pt;
  logic              reload_evt;
  logic              stop_evt;
  logic              flag_set;
  logic              flag_clr;
  logic              is_run;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    is_cfg = (a == ENV_ADR) || (a == AMP_H_ADR) || (a == AMP_L_ADR) ||
             (a == STEP_H_ADR) || (a == STEP_L_ADR) || (a == THR_H_ADR) ||
             (a == THR_L_ADR) || (a == DUR_ADR);
  endfunction

  // ----------------------------------------
  // event logic
  // ----------------------------------------
  assign is_run     = (state_ff == ST_RUN);
  assign start_evt  = !is_run && config_ready_ff && !stop_req_ff;
  assign reload_pt  = dur_end && (!en_buf_ff || reached);
  assign reload_evt = start_evt || (reload_pt && config_ready_ff && !stop_req_ff);
  assign stop_evt   = is_run && (stop_req_ff || (reload_pt && !config_ready_ff));
  assign flag_set   = start_evt || (is_run && reload_pt);
  assign flag_clr   = wr && (addr == IF_ADR) && wdata[NDF_BIT];

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  tone_cycle_count u_count (
    .clk     (clk),
    .reset   (reset),
    .clear   (!is_run || stop_req_ff),
    .tone    (tone),
    .tone_cycles_per_step     (dur_buf_ff),
    .count   (count),
    .dur_end (dur_end)
  );

  envelope_step u_step (
    .amp      (live_amp_ff),
    .frac     (frac_ff),
    .step     (step_buf_ff),
    .thr      (thr_buf_ff),
    .shape    (shape_buf_ff),
    .decay    (dir_buf_ff),
    .nxt_amp  (nxt_amp),
    .nxt_frac (nxt_frac),
    .reached  (reached)
  );

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      config_ready_ff <= 1'b0;
      stop_req_ff     <= 1'b0;
    end
    else if (wr && addr == CTRL_ADR)
    begin
      config_ready_ff <= wdata[RDR_BIT];
      stop_req_ff     <= wdata[STP_BIT];
    end
    else if (wr && is_cfg(addr))
      config_ready_ff <= 1'b0;
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      env_en_ff    <= 1'b0;
      env_shape_ff <= SHAPE_LINEAR;
      env_dir_ff   <= 1'b0;
      cfg_amp_ff   <= AMP_ZERO;
      amp_step_ff  <= AMP_ZERO;
      amp_thr_ff   <= AMP_ZERO;
      dur_ff       <= DUR_ZERO;
      irq_en_ff    <= 1'b0;
    end
    else if (wr)
    begin
      case (addr)
        ENV_ADR:
        begin
          env_en_ff    <= wdata[ENV_EN_BIT];
          env_shape_ff <= shape_e'(wdata[SHAPE_LSB+1:SHAPE_LSB]);
          env_dir_ff   <= wdata[DIR_BIT];
        end
        AMP_H_ADR:  cfg_amp_ff[AMP_W-1:DATA_W]  <= wdata[HI_W-1:0];
        AMP_L_ADR:  cfg_amp_ff[DATA_W-1:0]      <= wdata;
        STEP_H_ADR: amp_step_ff[AMP_W-1:DATA_W] <= wdata[HI_W-1:0];
        STEP_L_ADR: amp_step_ff[DATA_W-1:0]     <= wdata;
        THR_H_ADR:  amp_thr_ff[AMP_W-1:DATA_W]  <= wdata[HI_W-1:0];
        THR_L_ADR:  amp_thr_ff[DATA_W-1:0]      <= wdata;
        DUR_ADR:    dur_ff                      <= wdata;
        IE_ADR:     irq_en_ff                   <= wdata[NDF_BIT];
        default:    irq_en_ff                   <= irq_en_ff;
      endcase
    end
  end

  // ----------------------------------------
  // run state
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (start_evt)
            state_ff <= ST_RUN;
        end
        ST_RUN:
        begin
          if (stop_evt)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // buffers loaded at reload
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      en_buf_ff    <= 1'b0;
      shape_buf_ff <= SHAPE_LINEAR;
      dir_buf_ff   <= 1'b0;
      step_buf_ff  <= AMP_ZERO;
      thr_buf_ff   <= AMP_ZERO;
      dur_buf_ff   <= DUR_ZERO;
    end
    else if (reload_evt)
    begin
      en_buf_ff    <= env_en_ff;
      shape_buf_ff <= env_shape_ff;
      dir_buf_ff   <= env_dir_ff;
      step_buf_ff  <= amp_step_ff;
      thr_buf_ff   <= amp_thr_ff;
      dur_buf_ff   <= dur_ff;
    end
  end

  // ----------------------------------------
  // live amplitude
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      live_amp_ff <= AMP_ZERO;
      frac_ff     <= FRAC_ZERO;
    end
    else if (reload_evt)
    begin
      live_amp_ff <= cfg_amp_ff;
      frac_ff     <= env_dir_ff ? FRAC_ONES : FRAC_ZERO;
    end
    else if (is_run && dur_end && en_buf_ff)
    begin
      live_amp_ff <= nxt_amp;
      frac_ff     <= nxt_frac;
    end
  end

  // ----------------------------------------
  // next-data flag
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      next_data_flag_ff <= 1'b0;
    else if (flag_set)
      next_data_flag_ff <= 1'b1;
    else if (flag_clr)
      next_data_flag_ff <= 1'b0;
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_ff <= '0;
    else if (rd)
    begin
      case (addr)
        CTRL_ADR:   rdata_ff <= DATA_W'({config_ready_ff, stop_req_ff});
        ENV_ADR:    rdata_ff <= {env_en_ff, 4'h0, env_shape_ff, env_dir_ff};
        AMP_H_ADR:  rdata_ff <= DATA_W'(cfg_amp_ff[AMP_W-1:DATA_W]);
        AMP_L_ADR:  rdata_ff <= cfg_amp_ff[DATA_W-1:0];
        STEP_H_ADR: rdata_ff <= DATA_W'(amp_step_ff[AMP_W-1:DATA_W]);
        STEP_L_ADR: rdata_ff <= amp_step_ff[DATA_W-1:0];
        THR_H_ADR:  rdata_ff <= DATA_W'(amp_thr_ff[AMP_W-1:DATA_W]);
        THR_L_ADR:  rdata_ff <= amp_thr_ff[DATA_W-1:0];
        DUR_ADR:    rdata_ff <= dur_ff;
        IE_ADR:     rdata_ff <= DATA_W'(irq_en_ff);
        IF_ADR:     rdata_ff <= DATA_W'(next_data_flag_ff);
        LIVE_H_ADR: rdata_ff <= DATA_W'(live_amp_ff[AMP_W-1:DATA_W]);
        LIVE_L_ADR: rdata_ff <= live_amp_ff[DATA_W-1:0];
        CNT_ADR:    rdata_ff <= count;
        default:    rdata_ff <= '0;
      endcase
    end
    else
      rdata_ff <= '0;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata          = rdata_ff;
  assign live_amplitude = live_amp_ff;
  assign reload_pulse   = reload_evt;
  assign stop_pulse     = stop_evt;
  assign running        = is_run;
  assign irq            = next_data_flag_ff && irq_en_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  flag_clear_a : assert property (flag_clr && !flag_set |=> !next_data_flag_ff && !irq)
    else $error("flag not cleared by one");
  flag_keep_a : assert property (wr && addr == IF_ADR && !wdata[NDF_BIT] && next_data_flag_ff
    |=> next_data_flag_ff)
    else $error("flag lost on zero write");
  irq_gate_a : assert property (!irq_en_ff && !(wr && addr == IE_ADR) |=> !irq)
    else $error("irq without enable");
  irq_hold_a : assert property (irq && !flag_clr && !(wr && addr == IE_ADR) |=> irq)
    else $error("irq level dropped");
  start_load_a : assert property (start_evt |=> next_data_flag_ff && live_amplitude == $past(cfg_amp_ff))
    else $error("start did not load");
  dur_reload_a : assert property (is_run && dur_end && !en_buf_ff && config_ready_ff && !stop_req_ff
    |=> is_run && next_data_flag_ff && live_amplitude == $past(cfg_amp_ff))
    else $error("duration reload missing");
  unready_stop_a : assert property (is_run && reload_pt && !config_ready_ff
    |=> !is_run && count == DUR_ZERO && next_data_flag_ff)
    else $error("unready stop missing");
  stop_clear_a : assert property (is_run && stop_req_ff |=> !is_run ##1 count == DUR_ZERO)
    else $error("stop left counter");
  cfg_ready_a : assert property (wr && is_cfg(addr) |=> !config_ready_ff)
    else $error("config write kept ready");
  live_ro_a : assert property (wr && addr == LIVE_L_ADR && !reload_evt && !dur_end
    |=> $stable(live_amplitude))
    else $error("live amplitude written");
  linear_up_a : assert property (is_run && dur_end && en_buf_ff && shape_buf_ff == SHAPE_LINEAR
    && !dir_buf_ff && !reload_evt && ({1'b0, live_amp_ff} + {1'b0, step_buf_ff}) <= {1'b0, AMP_MAX}
    |=> live_amplitude == $past(live_amp_ff) + $past(step_buf_ff))
    else $error("linear attack step wrong");
  cfg_keep_a : assert property (is_run && dur_end && en_buf_ff && !wr |=> $stable(cfg_amp_ff))
    else $error("configured amplitude changed");
  linear_down_a : assert property (is_run && dur_end && en_buf_ff && shape_buf_ff == SHAPE_LINEAR
    && dir_buf_ff && !reload_evt && live_amp_ff >= step_buf_ff
    |=> live_amplitude == $past(live_amp_ff) - $past(step_buf_ff))
    else $error("linear decay step wrong");
  rsvd_hold_a : assert property (is_run && dur_end && en_buf_ff && shape_buf_ff == SHAPE_RSVD
    && !reload_evt |=> $stable(live_amplitude))
    else $error("reserved shape moved amplitude");
  env_off_a : assert property (is_run && dur_end && !en_buf_ff && !config_ready_ff
    |=> $stable(live_amplitude))
    else $error("amplitude stepped without envelope");
  reload_load_a : assert property (reload_evt |=> live_amplitude == $past(cfg_amp_ff))
    else $error("reload did not copy amplitude");
  stop_run_a : assert property (stop_pulse |=> !running)
    else $error("stop pulse left generator running");
  idle_count_a : assert property (!is_run |=> count == DUR_ZERO)
    else $error("counter moved while idle");

  start_c : cover property (start_evt);
  step_c : cover property (is_run && dur_end && en_buf_ff && !reached);
  thr_reload_c : cover property (is_run && dur_end && en_buf_ff && reached && config_ready_ff);
  unready_c : cover property (is_run && reload_pt && !config_ready_ff);
  stop_c : cover property (is_run && stop_req_ff);
endmodule

// *** core/sound_env_pkg.sv ***
// What this block does
// - linear step adds or subtracts step value
// - threshold reached ends attack or decay
// - duration is setting plus one tone cycles
// - envelope steps amplitude at each duration end that does not reload
// - no envelope: duration end reloads if ready
// - no envelope: duration end stops if unready
// - interrupt needs flag and enable both set
// - reload into buffers sets next-data flag
// - reload point while unready sets flag
// - write one clears flag, zero ignored
// - live amplitude loaded at reload, read only
// - envelope changes only live amplitude copy
// - counter advances on tone falling edge
// - counter wraps to zero at setting
// - every stop clears duration counter
// - shape field selects linear, gong, exponential
// - direction zero attacks, one decays
// - config write clears ready, software resets
// - tone cycle is two half periods
package sound_env_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int AMP_W  = 11;
  localparam int DUR_W  = 8;
  localparam int FRAC_W = 5;

  localparam logic [ADDR_W-1:0] CTRL_ADR   = 5'h00;
  localparam logic [ADDR_W-1:0] ENV_ADR    = 5'h01;
  localparam logic [ADDR_W-1:0] AMP_H_ADR  = 5'h06;
  localparam logic [ADDR_W-1:0] AMP_L_ADR  = 5'h07;
  localparam logic [ADDR_W-1:0] STEP_H_ADR = 5'h08;
  localparam logic [ADDR_W-1:0] STEP_L_ADR = 5'h09;
  localparam logic [ADDR_W-1:0] THR_H_ADR  = 5'h0a;
  localparam logic [ADDR_W-1:0] THR_L_ADR  = 5'h0b;
  localparam logic [ADDR_W-1:0] DUR_ADR    = 5'h0c;
  localparam logic [ADDR_W-1:0] IE_ADR     = 5'h0d;
  localparam logic [ADDR_W-1:0] IF_ADR     = 5'h0e;
  localparam logic [ADDR_W-1:0] LIVE_H_ADR = 5'h10;
  localparam logic [ADDR_W-1:0] LIVE_L_ADR = 5'h11;
  localparam logic [ADDR_W-1:0] CNT_ADR    = 5'h12;

  localparam int RDR_BIT    = 1;
  localparam int STP_BIT    = 0;
  localparam int ENV_EN_BIT = 7;
  localparam int SHAPE_LSB  = 1;
  localparam int DIR_BIT    = 0;
  localparam int NDF_BIT    = 0;
  localparam int HI_W       = AMP_W - DATA_W;

  localparam logic [AMP_W-1:0]  AMP_MAX   = 11'h7ff;
  localparam logic [AMP_W-1:0]  AMP_ZERO  = 11'h000;
  localparam logic [FRAC_W-1:0] FRAC_ONES = 5'h1f;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 5'h00;
  localparam logic [DUR_W-1:0]  DUR_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    SHAPE_LINEAR = 2'b00,
    SHAPE_GONG   = 2'b01,
    SHAPE_EXP    = 2'b10,
    SHAPE_RSVD   = 2'b11
  } shape_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } run_e;
endpackage

// *** core/tone_cycle_count.sv ***
module tone_cycle_count
  import sound_env_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic                            clear,
  input  wire logic                            tone,
  input  wire logic [sound_env_pkg::DUR_W-1:0] tone_cycles_per_step,
  output logic      [sound_env_pkg::DUR_W-1:0] count,
  output logic                                 dur_end
);
  // ----------------------------------------
  // falling edge of tone
  // ----------------------------------------
  logic tone_ff;
  logic fall;

  always_ff @(posedge clk)
  begin
    if (reset)
      tone_ff <= 1'b0;
    else
      tone_ff <= tone;
  end

  // each fall closes one tone cycle of two half periods
  assign fall    = tone_ff && !tone && !clear;
  assign dur_end = fall && (count == tone_cycles_per_step);

  // ----------------------------------------
  // duration counter
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset || clear)
      count <= DUR_ZERO;
    else if (dur_end)
      count <= DUR_ZERO;
    else if (fall)
      count <= count + 8'h01;
  end

  cnt_wrap_a : assert property (@(posedge clk) disable iff (reset)
    fall && count == tone_cycles_per_step |=> count == DUR_ZERO) else $error("counter did not wrap");
  cnt_step_a : assert property (@(posedge clk) disable iff (reset)
    fall && count != tone_cycles_per_step |=> count == $past(count) + 8'h01) else $error("counter did not step");
endmodule

// *** core/envelope_step.sv ***
module envelope_step
  import sound_env_pkg::*;
(
  input  wire logic [sound_env_pkg::AMP_W-1:0]  amp,
  input  wire logic [sound_env_pkg::FRAC_W-1:0] frac,
  input  wire logic [sound_env_pkg::AMP_W-1:0]  step,
  input  wire logic [sound_env_pkg::AMP_W-1:0]  thr,
  input  wire sound_env_pkg::shape_e            shape,
  input  wire logic                             decay,
  output logic      [sound_env_pkg::AMP_W-1:0]  nxt_amp,
  output logic      [sound_env_pkg::FRAC_W-1:0] nxt_frac,
  output logic                                  reached
);
  // ----------------------------------------
  // one envelope step
  // ----------------------------------------
  logic [AMP_W+FRAC_W-1:0] whole;
  logic [AMP_W+FRAC_W-1:0] delta;
  logic [AMP_W+FRAC_W:0]   gsum;
  logic [AMP_W:0]          lsum;

  always_comb
  begin
    whole    = {amp, frac};
    delta    = whole >> FRAC_W;
    gsum     = {1'b0, whole} + {1'b0, delta};
    lsum     = {1'b0, amp} + {1'b0, step};
    nxt_amp  = amp;
    nxt_frac = frac;
    case (shape)
      SHAPE_LINEAR:
      begin
        if (!decay)
          nxt_amp = lsum[AMP_W] ? AMP_MAX : lsum[AMP_W-1:0];
        else
          nxt_amp = (amp < step) ? AMP_ZERO : amp - step;
      end
      SHAPE_GONG:
      begin
        if (!decay)
        begin
          if (gsum[AMP_W+FRAC_W])
            {nxt_amp, nxt_frac} = {AMP_MAX, FRAC_ONES};
          else
            {nxt_amp, nxt_frac} = gsum[AMP_W+FRAC_W-1:0];
        end
        else
          {nxt_amp, nxt_frac} = whole - delta;
      end
      SHAPE_EXP:
      begin
        if (!decay)
          nxt_amp = amp[AMP_W-1] ? AMP_MAX : {amp[AMP_W-2:0], 1'b1};
        else
          nxt_amp = amp >> 1;
      end
      default:
      begin
        nxt_amp  = amp;
        nxt_frac = frac;
      end
    endcase
    reached = decay ? (nxt_amp <= thr) : (nxt_amp >= thr);
  end
endmodule

// *** bench/sound_envelope_duration_irq_test.sv ***
module sound_envelope_duration_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sound_env_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              tone;
  logic [AMP_W-1:0]  live_amplitude;
  logic              reload_pulse;
  logic              stop_pulse;
  logic              running;
  logic              irq;
  int                n_fail;
  int                tests_run;
  int                n_stop = 0;
  int                n_reload = 0;
  int                k;
  int                kr;
  logic [7:0]        rv;
  logic [10:0]       v11;
  logic [ADDR_W-1:0] rst_adr [7] = '{CTRL_ADR, ENV_ADR, DUR_ADR, IE_ADR, IF_ADR, CNT_ADR, 5'h1f};
  logic [10:0]       shape_exp [8] = '{11'h140, 11'h108, 11'h201, 11'h100,
                                      11'h0c0, 11'h0f8, 11'h080, 11'h100};

  sound_envelope_duration_irq DUT (
    .clk            (clk),
    .reset          (reset),
    .addr           (addr),
    .wdata          (wdata),
    .wr             (wr),
    .rd             (rd),
    .rdata          (rdata),
    .tone           (tone),
    .live_amplitude (live_amplitude),
    .reload_pulse   (reload_pulse),
    .stop_pulse     (stop_pulse),
    .running        (running),
    .irq            (irq)
  );

  always #2.5 clk = ~clk;

  always @(posedge clk)
  begin
    if (stop_pulse === 1'b1)
      n_stop <= n_stop + 1;
    if (reload_pulse === 1'b1)
      n_reload <= n_reload + 1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic w11(input logic [ADDR_W-1:0] a, input logic [10:0] v);
    wr_reg(a, {5'h00, v[10:8]});
    wr_reg(a | 5'h01, v[7:0]);
  endtask

  task automatic rd11(input logic [ADDR_W-1:0] a, output logic [10:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd_reg(a, h);
    rd_reg(a | 5'h01, l);
    v = {h[2:0], l};
  endtask

  task automatic tone_cyc(input int n);
    repeat (n)
    begin
      @(posedge clk);
      tone <= 1'b1;
      repeat (2) @(posedge clk);
      tone <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_run(input logic exp);
    int i;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      #1;
      if (running === exp)
        break;
    end
    if (running !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t running did not settle", $time);
      test_done();
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    clk       = 1'b0;
    reset     = 1'b1;
    addr      = '0;
    wdata     = '0;
    wr        = 1'b0;
    rd        = 1'b0;
    tone      = 1'b0;
    n_fail    = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (rst_adr[i])
    begin
      rd_reg(rst_adr[i], rv);
      check(rv, 16'h0000);
    end
    check(irq, 1'b0);
    // plain reload run
    wr_reg(IE_ADR, 8'h01);
    wr_reg(DUR_ADR, 8'h02);
    w11(AMP_H_ADR, 11'h123);
    wr_reg(STEP_H_ADR, 8'hff);
    rd_reg(STEP_H_ADR, rv);
    check(rv, 16'h0007);
    wr_reg(CTRL_ADR, 8'h02);
    wait_run(1'b1);
    check(live_amplitude, 16'h0123);
    check(irq, 1'b1);
    rd_reg(IF_ADR, rv);
    check(rv, 16'h0001);
    wr_reg(LIVE_L_ADR, 8'h00);
    rd11(LIVE_H_ADR, v11);
    check(v11, 16'h0123);
    wr_reg(IF_ADR, 8'h00);
    check(irq, 1'b1);
    wr_reg(IF_ADR, 8'h01);
    check(irq, 1'b0);
    rd_reg(IF_ADR, rv);
    check(rv, 16'h0000);
    tone_cyc(1);
    rd_reg(CNT_ADR, rv);
    check(rv, 16'h0001);
    w11(AMP_H_ADR, 11'h055);
    rd_reg(CTRL_ADR, rv);
    check(rv, 16'h0000);
    wr_reg(CTRL_ADR, 8'h02);
    tone_cyc(1);
    rd_reg(CNT_ADR, rv);
    check(rv, 16'h0002);
    check(live_amplitude, 16'h0123);
    k = n_reload;
    tone_cyc(1);
    check(live_amplitude, 16'h0055);
    check(16'(n_reload - k), 16'h0001);
    rd_reg(CNT_ADR, rv);
    check(rv, 16'h0000);
    rd_reg(IF_ADR, rv);
    check(rv, 16'h0001);
    check(running, 1'b1);
    // stop bit mid duration
    tone_cyc(1);
    wr_reg(CTRL_ADR, 8'h03);
    wait_run(1'b0);
    rd_reg(CNT_ADR, rv);
    check(rv, 16'h0000);
    wr_reg(CTRL_ADR, 8'h02);
    wait_run(1'b1);
    // unready duration end stops
    wr_reg(IF_ADR, 8'h01);
    wr_reg(IE_ADR, 8'h00);
    wr_reg(AMP_L_ADR, 8'h55);
    k = n_stop;
    kr = n_reload;
    tone_cyc(3);
    check(running, 1'b0);
    check(16'(n_reload - kr), 16'h0000);
    check(16'(n_stop - k), 16'h0001);
    rd_reg(CNT_ADR, rv);
    check(rv, 16'h0000);
    rd_reg(IF_ADR, rv);
    check(rv, 16'h0001);
    check(irq, 1'b0);
    wr_reg(IE_ADR, 8'h01);
    check(irq, 1'b1);
    // linear attack up to threshold
    wr_reg(IF_ADR, 8'h01);
    w11(STEP_H_ADR, 11'h040);
    w11(THR_H_ADR, 11'h1c0);
    wr_reg(DUR_ADR, 8'h00);
    wr_reg(ENV_ADR, 8'h80);
    w11(AMP_H_ADR, 11'h100);
    wr_reg(CTRL_ADR, 8'h02);
    wait_run(1'b1);
    tone_cyc(1);
    check(live_amplitude, 16'h0140);
    rd11(AMP_H_ADR, v11);
    check(v11, 16'h0100);
    tone_cyc(1);
    check(live_amplitude, 16'h0180);
    check(running, 1'b1);
    wr_reg(IF_ADR, 8'h01);
    wr_reg(AMP_L_ADR, 8'h00);
    k = n_stop;
    tone_cyc(1);
    check(running, 1'b0);
    check(16'(n_stop - k), 16'h0001);
    rd_reg(IF_ADR, rv);
    check(rv, 16'h0001);
    // every shape, both directions
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(CTRL_ADR, 8'h01);
      wr_reg(ENV_ADR, 8'h80 | 8'((c % 4) * 2) | 8'(c / 4));
      w11(AMP_H_ADR, 11'h100);
      w11(STEP_H_ADR, 11'h040);
      w11(THR_H_ADR, (c < 4) ? 11'h7ff : 11'h000);
      wr_reg(DUR_ADR, 8'h00);
      wr_reg(CTRL_ADR, 8'h02);
      wait_run(1'b1);
      check(live_amplitude, 16'h0100);
      tone_cyc(1);
      check(live_amplitude, {5'h00, shape_exp[c]});
    end
    test_done();
  end
endmodule
